// ==== pkg/mic_regs.svh ====
// Function
// - Seven request sources feed the controller.
// - Global enable, control bit 7, passes unmasked requests or blocks all.
// - Each source has an enable bit; cleared enable blocks that source.
// - Any reset clears the global enable.
// - Return-from-interrupt instruction sets the global enable again.
// - Pin, port change and timer0 flags live in the control register.
// - Write, converter, comparator, timer1 flags/enables live in peripheral registers.
// - Servicing clears global enable, pushes return address, loads vector 0004h.
// - Flags set by events regardless of any enable bit.
// - Asynchronous pin or port events are taken three or four cycles later.
// - Latency is the same for one- or two-cycle instructions.
// - Requests masked by a global-enable clear stay pending until re-enable.
// - Wake-up sets peripheral flag of the waking source, bits 7,6,3,0.
// - Wake-up by interrupt with global enable set loads vector 0004h.
// - External pin is edge triggered, polarity by edge select; sets flag.
// - Timer0 count rollover FFh to 00h sets timer0 overflow flag.
// - Change on a selected port pin sets the port change flag.
// - Converter completion sets the conversion done flag, regardless of its enable.
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
`define MIC_CTRL_GEN      7
`define MIC_CTRL_PEIE     6
`define MIC_CTRL_T0IE     5
`define MIC_CTRL_EXTIE    4
`define MIC_CTRL_PCIE     3
`define MIC_CTRL_T0F      2
`define MIC_CTRL_EXTF     1
`define MIC_CTRL_PCF      0
`define MIC_PER_WR        7
`define MIC_PER_CONV      6
`define MIC_PER_CMP       3
`define MIC_PER_TMR1      0
`define MIC_PER_MASK      8'hC9
`define MIC_CTRL_RESET    8'h00
`define MIC_PER_RESET     8'h00
`define MIC_VECTOR        13'h0004
`define MIC_LATENCY       2'd2
`endif

// ==== pkg/mic_pkg.sv ====
package mic_pkg;
  typedef enum logic [2:0] {
    MIC_RUN   = 3'b001,
    MIC_DUMMY = 3'b010,
    MIC_VECT  = 3'b100
  } mic_state_e;
endpackage : mic_pkg

// ==== rtl/mic_edge.sv ====
`timescale 1ns/1ps
// Edge and change detector for the pin and port sources
module mic_edge #(
  parameter int WIDTH = 6
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] pin_sel,
  input  wire logic             ext_edge_select,
  input  wire logic [2:0]       ext_bit,
  output logic                  ext_event,
  output logic                  change_event
);
  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("mic_edge WIDTH out of range");
  end
  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic             armed;
  } mic_edge_s;
  mic_edge_s st, next_st;
  logic cur_ext, old_ext;

  ////////////////////////////////////////////////////////////////////////
  // Compare against last sample; first cycle after reset only arms
  always_comb begin
    next_st       = st;
    next_st.prev  = pins;
    next_st.armed = 1'b1;
    cur_ext       = pins[ext_bit];
    old_ext       = st.prev[ext_bit];
    ext_event     = st.armed && (ext_edge_select ? (cur_ext && !old_ext)
                                                 : (!cur_ext && old_ext));
    change_event  = st.armed && |((pins ^ st.prev) & pin_sel);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : mic_edge

// ==== rtl/mic_irq_ctrl.sv ====
`timescale 1ns/1ps
`include "mic_regs.svh"
// Interrupt controller: flags, enables, request and vector sequencing
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int PINS = 6
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic [PINS-1:0] port_pins,
  input  wire logic [PINS-1:0] change_sel,
  input  wire logic [2:0]      ext_pin_index,
  input  wire logic            ext_edge_select,
  input  wire logic [7:0]      timer0_count,
  input  wire logic            timer0_tick,
  input  wire logic            conv_done,
  input  wire logic            cmp_change,
  input  wire logic            tmr1_rollover,
  input  wire logic            write_done,
  input  wire logic            asleep,
  input  wire logic            ctrl_we,
  input  wire logic [7:0]      ctrl_wdata,
  input  wire logic            per_flag_we,
  input  wire logic            per_en_we,
  input  wire logic [7:0]      per_wdata,
  input  wire logic            return_from_irq_instr,
  input  wire logic [12:0]     pc_now,
  output logic [7:0]           irq_control_reg,
  output logic [7:0]           peripheral_flag_reg,
  output logic [7:0]           peripheral_enable_reg,
  output logic                 irq_request,
  output logic                 wake,
  output logic                 take_irq,
  output logic                 stack_push,
  output logic [12:0]          push_addr,
  output logic                 pc_load,
  output logic [12:0]          pc_vector
);
  initial begin
    if (PINS < 3 || PINS > 8) $error("mic_irq_ctrl PINS out of range");
  end

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  pflag;
    logic [7:0]  pen;
    mic_state_e  fsm;
    logic        req_q;
    logic        push;
    logic [12:0] ret;
    logic        load;
  } mic_s;
  mic_s st, next_st;

  logic ext_event;
  logic change_event;
  logic t0_roll;
  logic pend;
  logic [7:0] ev_ctrl;
  logic [7:0] ev_per;

  mic_edge #(.WIDTH(PINS)) u_edge (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .pins            (port_pins),
    .pin_sel         (change_sel),
    .ext_edge_select (ext_edge_select),
    .ext_bit         (ext_pin_index),
    .ext_event       (ext_event),
    .change_event    (change_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pending test shared by request and wake outputs
  function automatic logic any_pending(input logic [7:0] c, input logic [7:0] f, input logic [7:0] e);
    logic per;
    per = c[`MIC_CTRL_PEIE] && |(f & e & `MIC_PER_MASK);
    return (c[`MIC_CTRL_T0IE] && c[`MIC_CTRL_T0F]) || (c[`MIC_CTRL_EXTIE] && c[`MIC_CTRL_EXTF])
        || (c[`MIC_CTRL_PCIE] && c[`MIC_CTRL_PCF]) || per;
  endfunction : any_pending

  ////////////////////////////////////////////////////////////////////////
  // Event vectors; timer0 rolls when FFh is ticked to 00h
  always_comb begin
    t0_roll = timer0_tick && (timer0_count == 8'hFF);
    ev_ctrl = '0;
    ev_ctrl[`MIC_CTRL_T0F]  = t0_roll;
    ev_ctrl[`MIC_CTRL_EXTF] = ext_event;
    ev_ctrl[`MIC_CTRL_PCF]  = change_event;
    ev_per = '0;
    ev_per[`MIC_PER_WR]   = write_done;
    ev_per[`MIC_PER_CONV] = conv_done;
    ev_per[`MIC_PER_CMP]  = cmp_change;
    ev_per[`MIC_PER_TMR1] = tmr1_rollover;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register update: writes first, then events OR in so a set beats a clear
  always_comb begin
    next_st = st;
    if (ctrl_we) begin
      next_st.ctrl = ctrl_wdata;
    end
    if (per_flag_we) begin
      next_st.pflag = per_wdata & `MIC_PER_MASK;
    end
    if (per_en_we) begin
      next_st.pen = per_wdata & `MIC_PER_MASK;
    end
    next_st.ctrl  = next_st.ctrl | ev_ctrl;
    next_st.pflag = next_st.pflag | ev_per;
    if (return_from_irq_instr) begin
      next_st.ctrl[`MIC_CTRL_GEN] = 1'b1;
    end
    pend = st.ctrl[`MIC_CTRL_GEN] && any_pending(st.ctrl, st.pflag, st.pen);
    next_st.req_q = pend;
    next_st.push  = 1'b0;
    next_st.load  = 1'b0;
    // Two fixed dummy cycles after the request keep latency instruction independent
    case (st.fsm)
      MIC_RUN: begin
        if (st.req_q && pend && !ctrl_we) begin
          next_st.fsm  = MIC_DUMMY;
          next_st.ret  = pc_now;
          next_st.push = 1'b1;
          next_st.ctrl[`MIC_CTRL_GEN] = 1'b0;
        end
      end
      MIC_DUMMY: begin
        next_st.fsm  = MIC_VECT;
        next_st.load = 1'b1;
      end
      MIC_VECT: begin
        next_st.fsm = MIC_RUN;
      end
      default: begin
        next_st.fsm = MIC_RUN;
      end
    endcase
  end

  // Reset clears all flags, enables and the global enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ctrl: `MIC_CTRL_RESET, pflag: `MIC_PER_RESET, pen: `MIC_PER_RESET,
               fsm: MIC_RUN, req_q: 1'b0, push: 1'b0, ret: 13'h0000, load: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; wake ignores the global enable so a masked source still wakes
  assign irq_control_reg       = st.ctrl;
  assign peripheral_flag_reg   = st.pflag;
  assign peripheral_enable_reg = st.pen;
  assign irq_request           = st.req_q;
  assign wake                  = asleep && any_pending(st.ctrl, st.pflag, st.pen);
  assign take_irq              = (st.fsm != MIC_RUN);
  assign stack_push            = st.push;
  assign push_addr             = st.ret;
  assign pc_load               = st.load;
  assign pc_vector             = `MIC_VECTOR;

  ////////////////////////////////////////////////////////////////////////
  AST_GLOBAL_BLOCKS: assert property (@(posedge core_clk) disable iff (!rst_n)
    !irq_control_reg[`MIC_CTRL_GEN] && !return_from_irq_instr |=> !irq_request)
    else $error("request without global enable");
  AST_RETURN_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
    return_from_irq_instr && !stack_push |=> irq_control_reg[`MIC_CTRL_GEN] || stack_push)
    else $error("return did not set global enable");
  AST_SERVICE_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_push && !$past(return_from_irq_instr) |-> !irq_control_reg[`MIC_CTRL_GEN])
    else $error("service left global enable set");
  AST_VECTOR_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_push |=> pc_load && pc_vector == 13'h0004)
    else $error("vector not loaded after push");
  AST_LATENCY: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(irq_request) && irq_control_reg[`MIC_CTRL_GEN] && !ctrl_we |=> ##[0:1] stack_push)
    else $error("service latency exceeded");
  AST_EXT_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_event |=> irq_control_reg[`MIC_CTRL_EXTF])
    else $error("pin edge lost");
  AST_T0_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    timer0_tick && timer0_count == 8'hFF |=> irq_control_reg[`MIC_CTRL_T0F])
    else $error("timer0 rollover lost");
  AST_CONV_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_done |=> peripheral_flag_reg[`MIC_PER_CONV])
    else $error("conversion flag lost");
  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
    per_flag_we && write_done |=> peripheral_flag_reg[`MIC_PER_WR])
    else $error("clear beat event");
  AST_REQ_TERM: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq_request |-> $past(irq_control_reg[`MIC_CTRL_GEN]))
    else $error("request without prior enable");
endmodule : mic_irq_ctrl

// ==== bench/mic_core_model.sv ====
`timescale 1ns/1ps
// Core side: program counter, eight-level return stack, return pulse
module mic_core_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ret_cmd,
  input  wire logic        stack_push,
  input  wire logic [12:0] push_addr,
  input  wire logic        pc_load,
  input  wire logic [12:0] pc_vector,
  output logic             return_from_irq_instr,
  output logic [12:0]      pc_now
);
  logic [12:0] stk [8];
  logic [2:0]  sp;
  ////////////////////////////////////////////////////////////////
  // Stack wraps silently on overflow, so deep nesting is not caught here
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_now <= 13'h0000;
      sp <= 3'h0;
      return_from_irq_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= ret_cmd;
      pc_now <= pc_now + 13'h0001;
      if (stack_push) begin
        stk[sp] <= push_addr;
        sp <= sp + 3'h1;
      end
      if (pc_load) pc_now <= pc_vector;
      if (ret_cmd) begin
        pc_now <= stk[sp - 3'h1];
        sp <= sp - 3'h1;
      end
    end
  end
endmodule : mic_core_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb;
  logic        core_clk, rst_n, ext_edge_select, timer0_tick, asleep, ret_cmd;
  logic        conv_done, cmp_change, tmr1_rollover, write_done, ctrl_we, per_flag_we, per_en_we;
  logic        return_from_irq_instr, irq_request, wake, take_irq, stack_push, pc_load;
  logic [5:0]  port_pins, change_sel;
  logic [2:0]  ext_pin_index;
  logic [7:0]  timer0_count, ctrl_wdata, per_wdata, m_ctrl, m_pflag, m_pen;
  logic [7:0]  irq_control_reg, peripheral_flag_reg, peripheral_enable_reg;
  logic [12:0] pc_now, push_addr, pc_vector, pc_prev;
  int          failures, total_checks, pushes, n;
  ////////////////////////////////////////////////////////////////
  mic_irq_ctrl #(.PINS(6)) DUT (.core_clk(core_clk), .rst_n(rst_n), .port_pins(port_pins),
    .change_sel(change_sel), .ext_pin_index(ext_pin_index), .ext_edge_select(ext_edge_select),
    .timer0_count(timer0_count), .timer0_tick(timer0_tick), .conv_done(conv_done),
    .cmp_change(cmp_change), .tmr1_rollover(tmr1_rollover), .write_done(write_done),
    .asleep(asleep), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .per_flag_we(per_flag_we),
    .per_en_we(per_en_we), .per_wdata(per_wdata), .return_from_irq_instr(return_from_irq_instr),
    .pc_now(pc_now), .irq_control_reg(irq_control_reg), .peripheral_flag_reg(peripheral_flag_reg),
    .peripheral_enable_reg(peripheral_enable_reg), .irq_request(irq_request), .wake(wake),
    .take_irq(take_irq), .stack_push(stack_push), .push_addr(push_addr), .pc_load(pc_load),
    .pc_vector(pc_vector));
  mic_core_model core (.core_clk(core_clk), .rst_n(rst_n), .ret_cmd(ret_cmd),
    .stack_push(stack_push), .push_addr(push_addr), .pc_load(pc_load), .pc_vector(pc_vector),
    .return_from_irq_instr(return_from_irq_instr), .pc_now(pc_now));
  ////////////////////////////////////////////////////////////////
  // Clock, push counter and watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (stack_push === 1'b1) pushes++;
  // Address the core held when the service was taken, for the return check
  always @(posedge core_clk) pc_prev <= pc_now;
  initial begin
    #(3000 * 50);
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  // Model registers against the design after selected steps
  task automatic chk_regs();
    `CHK("ctrl", m_ctrl, irq_control_reg)
    `CHK("pflag", m_pflag, peripheral_flag_reg)
    `CHK("pen", m_pen, peripheral_enable_reg)
  endtask : chk_regs
  // Register write: 0 control, 1 peripheral flags, 2 peripheral enables
  task automatic wr(input int r, input logic [7:0] v);
    @(posedge core_clk);
    ctrl_we <= (r == 0);
    per_flag_we <= (r == 1);
    per_en_we <= (r == 2);
    ctrl_wdata <= v;
    per_wdata <= v;
    @(posedge core_clk);
    {ctrl_we, per_flag_we, per_en_we} <= 3'b000;
    if (r == 0) m_ctrl = v;
    else if (r == 1) m_pflag = v & 8'hC9;
    else m_pen = v & 8'hC9;
    tick(1);
  endtask : wr
  task automatic pulse(input int b);
    @(posedge core_clk);
    write_done <= (b == 7);
    conv_done <= (b == 6);
    cmp_change <= (b == 3);
    tmr1_rollover <= (b == 0);
    @(posedge core_clk);
    {write_done, conv_done, cmp_change, tmr1_rollover} <= 4'h0;
    m_pflag[b] = 1'b1;
  endtask : pulse
  task automatic pins(input logic [5:0] v);
    @(posedge core_clk);
    port_pins <= v;
  endtask : pins
  task automatic ret();
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
    m_ctrl[7] = 1'b1;
  endtask : ret
  task automatic wait_push(output int k);
    k = 0;
    while (stack_push !== 1'b1 && k < 12) begin
      tick(1);
      k++;
    end
  endtask : wait_push
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, timer0_tick, asleep, ret_cmd, conv_done, cmp_change, tmr1_rollover} = '0;
    {write_done, ctrl_we, per_flag_we, per_en_we, ctrl_wdata, per_wdata, timer0_count} = '0;
    {m_ctrl, m_pflag, m_pen, port_pins} = '0;
    ext_edge_select = 1'b1;
    change_sel = 6'h01;
    ext_pin_index = 3'd2;
    void'($urandom(52129));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    chk_regs();
    `CHK("req", 1'b0, irq_request)
    $display("test reset done");
    for (int i = 7; i >= 0; i--) if (((8'hC9 >> i) & 8'h01) != 8'h00) pulse(i);
    repeat (4) begin
      @(posedge core_clk);
      timer0_count <= 8'($urandom_range(254));
      timer0_tick <= 1'b1;
    end
    @(posedge core_clk) timer0_count <= 8'hFF;
    @(posedge core_clk) timer0_tick <= 1'b0;
    pins(6'h04);
    pins(6'h0C);
    tick(2);
    `CHK("nosel", 1'b0, irq_control_reg[0])
    pins(6'h0D);
    tick(3);
    m_ctrl = 8'h07;
    chk_regs();
    `CHK("req", 1'b0, irq_request)
    $display("test flags done");
    // Unused peripheral bits are masked; same-cycle events beat the clear
    wr(1, 8'($urandom));
    chk_regs();
    @(posedge core_clk);
    per_flag_we <= 1'b1;
    per_wdata <= 8'h00;
    conv_done <= 1'b1;
    write_done <= 1'b1;
    @(posedge core_clk);
    {per_flag_we, conv_done, write_done} <= 3'b000;
    m_pflag = 8'hC0;
    wr(0, 8'hC0);
    tick(6);
    chk_regs();
    `CHK("pushes", 0, pushes)
    $display("test clear and mask done");
    wr(1, 8'h00);
    wr(0, 8'h90);
    pins(6'h09);
    tick(4);
    `CHK("fall", 0, pushes)
    pins(6'h0D);
    wait_push(n);
    `CHK("latency", 1'b1, (n >= 3 && n <= 4))
    `CHK("ret_addr", pc_prev, push_addr)
    `CHK("take", 1'b1, take_irq)
    `CHK("global_en", 1'b0, irq_control_reg[7])
    tick(1);
    `CHK("load", 1'b1, pc_load)
    `CHK("vec", 13'h0004, pc_vector)
    `CHK("src", 1'b1, irq_control_reg[1])
    wr(0, 8'h10);
    ret();
    tick(10);
    chk_regs();
    `CHK("once", 1, pushes)
    $display("test service done");
    wr(2, 8'h40);
    wr(0, 8'h40);
    @(posedge core_clk) asleep <= 1'b1;
    pulse(6);
    tick(1);
    `CHK("wake", 1'b1, wake)
    tick(6);
    `CHK("held", 1'b0, irq_request)
    @(posedge core_clk) asleep <= 1'b0;
    ret();
    wait_push(n);
    `CHK("pend", 1'b1, (n < 12))
    m_ctrl[7] = 1'b0;
    tick(2);
    chk_regs();
    $display("test pending done");
    // Mid-run reset with the global enable set; pins stay high, and the first cycle after reset only arms, so no false edge
    wr(0, 8'h80);
    @(posedge core_clk) rst_n <= 1'b0;
    @(posedge core_clk) rst_n <= 1'b1;
    {m_ctrl, m_pflag, m_pen} = '0;
    tick(2);
    chk_regs();
    `CHK("req_rst", 1'b0, irq_request)
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb
